// File: design/tbd_pkg.sv
package tbd_pkg;

  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  // Run indicator goes dark after this long without an update cycle
  localparam int unsigned RUN_TIMEOUT_MS = 100;
  localparam int unsigned RUN_TIMEOUT_CYC = CLK_HZ / 1000 * RUN_TIMEOUT_MS;
  // Flash timing base: one tick per millisecond
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TICK_MS = TICK_US / 1000;
  localparam int unsigned PULSE_MS = 200;
  localparam int unsigned GAP_MS = 1000;
  localparam int unsigned REST_MS = 2000;
  localparam int unsigned FLICK_MS = 50;
  localparam logic [11:0] PULSE_TICKS = 12'(PULSE_MS / TICK_MS);
  localparam logic [11:0] GAP_TICKS = 12'(GAP_MS / TICK_MS);
  localparam logic [11:0] REST_TICKS = 12'(REST_MS / TICK_MS);
  localparam logic [11:0] FLICK_TICKS = 12'(FLICK_MS / TICK_MS);

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_STATE = 12'h000;
  localparam logic [11:0] OFS_FAULT = 12'h004;
  localparam logic [11:0] OFS_CTRL = 12'h008;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h00C;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h010;

  // State byte fields
  localparam int unsigned ST_BUS_ERR = 0;
  localparam int unsigned ST_RETRIG = 2;
  localparam logic [7:0] STATE_RST = 8'h00;

  // Control fields (write one to act)
  localparam int unsigned CTRL_CLR_FAULT = 0;
  localparam int unsigned CTRL_CLR_RETRIG = 1;

  // Interrupt status and mask fields
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_FAULT = 0;
  localparam int unsigned IRQ_WARN = 1;
  localparam int unsigned IRQ_RETRIG = 2;
  localparam int unsigned IRQ_RUNLOST = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // ---------------------------------------------------------------
  // Message read request selectors
  // ---------------------------------------------------------------
  localparam logic [15:0] MSG_PORT = 16'h0001;
  localparam logic [31:0] MSG_GROUP = 32'h0000_0006;
  localparam logic [31:0] MSG_OFFSET = 32'h000C_9000;
  localparam logic [15:0] MSG_LEN = 16'h0001;

  // ---------------------------------------------------------------
  // Fault codes and arguments
  // ---------------------------------------------------------------
  localparam logic [7:0] FC_EMC = 8'h00;
  localparam logic [7:0] FC_CFG = 8'h01;
  localparam logic [7:0] FC_CMD = 8'h03;
  localparam logic [7:0] FC_BREAK = 8'h04;
  localparam logic [7:0] FC_REG = 8'h05;
  localparam logic [7:0] FC_OVERRUN = 8'h07;
  localparam logic [7:0] FA_NONE = 8'h00;
  localparam logic [7:0] FA_CFG_CHK = 8'h00;
  localparam logic [7:0] FA_CFG_OVF = 8'h01;
  localparam logic [7:0] FA_CFG_TYPE = 8'h02;

  // ---------------------------------------------------------------
  // Flash sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    FL_IDLE = 7'h01,
    FL_CODE_ON = 7'h02,
    FL_CODE_OFF = 7'h04,
    FL_GAP = 7'h08,
    FL_ARG_ON = 7'h10,
    FL_ARG_OFF = 7'h20,
    FL_REST = 7'h40
  } tbd_flash_e;

endpackage : tbd_pkg

// File: design/tbd_flasher.sv
`timescale 1ns/1ps
module tbd_flasher
  import tbd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic show,
  input wire logic [7:0] code,
  input wire logic [7:0] arg,
  output logic led_q
);

  tbd_flash_e state_q;
  logic [11:0] cnt_q;
  logic [7:0] left_q;
  logic [7:0] code_q;
  logic [7:0] arg_q;
  logic [11:0] on_len;

  // Code 0 has no count to show, so it flickers fast instead
  assign on_len = (code_q == FC_EMC) ? FLICK_TICKS : PULSE_TICKS;

  // ---------------------------------------------------------------
  // Burst, pause, burst, rest, repeat
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= FL_IDLE;
      cnt_q <= 12'h000;
      left_q <= 8'h00;
      code_q <= 8'h00;
      arg_q <= 8'h00;
      led_q <= 1'b0;
    end else if (!show) begin
      state_q <= FL_IDLE;
      cnt_q <= 12'h000;
      led_q <= 1'b0;
    end else if (tick) begin
      cnt_q <= cnt_q + 12'h001;
      case (state_q)
        FL_IDLE: begin
          // Code and argument are sampled once per round
          code_q <= code;
          arg_q <= arg;
          left_q <= code;
          cnt_q <= 12'h000;
          led_q <= 1'b1;
          state_q <= FL_CODE_ON;
        end
        FL_CODE_ON: begin
          if (cnt_q >= on_len - 12'h001) begin
            cnt_q <= 12'h000;
            led_q <= 1'b0;
            left_q <= left_q - 8'h01;
            state_q <= FL_CODE_OFF;
          end
        end
        FL_CODE_OFF: begin
          if (cnt_q >= on_len - 12'h001) begin
            cnt_q <= 12'h000;
            if (code_q == FC_EMC || left_q != 8'h00) begin
              led_q <= 1'b1;
              state_q <= FL_CODE_ON;
            end else begin
              state_q <= FL_GAP;
            end
          end
        end
        FL_GAP: begin
          if (cnt_q >= GAP_TICKS - 12'h001) begin
            cnt_q <= 12'h000;
            left_q <= arg_q;
            if (arg_q != 8'h00) begin
              led_q <= 1'b1;
              state_q <= FL_ARG_ON;
            end else begin
              state_q <= FL_REST;
            end
          end
        end
        FL_ARG_ON: begin
          if (cnt_q >= PULSE_TICKS - 12'h001) begin
            cnt_q <= 12'h000;
            led_q <= 1'b0;
            left_q <= left_q - 8'h01;
            state_q <= FL_ARG_OFF;
          end
        end
        FL_ARG_OFF: begin
          if (cnt_q >= PULSE_TICKS - 12'h001) begin
            cnt_q <= 12'h000;
            if (left_q != 8'h00) begin
              led_q <= 1'b1;
              state_q <= FL_ARG_ON;
            end else begin
              state_q <= FL_REST;
            end
          end
        end
        FL_REST: begin
          if (cnt_q >= REST_TICKS - 12'h001) begin
            cnt_q <= 12'h000;
            state_q <= FL_IDLE;
          end
        end
        default: begin
          state_q <= FL_IDLE;
          led_q <= 1'b0;
        end
      endcase
    end
  end

endmodule : tbd_flasher

// File: design/tbd_diag.sv
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// What this block does
// - State byte: bit0 bus error, bit2 retriggered
// - Message read with fixed selectors returns state
// - Run indicator dark without update cycles
// - Fault indicator dark unless fault or overrun warning, then flashes
// - Code 0, no argument: disturbance problems
// - Code 1 args: checksum, overflow, unknown type
// - Code 3 arg 0: bus command failure
// - Code 4: data break behind position n
// - Code 5 arg n: register access failure
// - Code 7 overrun warning latched until restart
module tbd_diag
  import tbd_pkg::*;
#(
  parameter int unsigned RUN_TIMEOUT = RUN_TIMEOUT_CYC,
  parameter int unsigned TICK_DIV = TICK_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Terminal bus engine events, one-cycle pulses
  input wire logic bus_cycle,
  input wire logic bus_retrig,
  input wire logic ev_emc,
  input wire logic ev_cfg_chk,
  input wire logic ev_cfg_ovf,
  input wire logic ev_cfg_type,
  input wire logic ev_cmd_fail,
  input wire logic ev_break,
  input wire logic ev_reg_fail,
  input wire logic ev_overrun,
  input wire logic [7:0] fault_pos,
  // Message read request
  input wire logic message_read_request,
  input wire logic [15:0] msg_port,
  input wire logic [31:0] selector_group,
  input wire logic [31:0] selector_offset,
  input wire logic [15:0] msg_len,
  output logic msg_ack,
  output logic msg_err,
  output logic [7:0] msg_data,
  // Indicators and interrupt
  output logic run_indicator,
  output logic fault_indicator,
  output logic irq
);

  // ---------------------------------------------------------------
  // Fault priority encoder
  // ---------------------------------------------------------------
  // Returns {valid, code, argument}; lower codes win a tie because
  // they point closer to the root cause.
  function automatic logic [16:0] pick_fault(
    input logic emc, input logic chk, input logic ovf,
    input logic typ, input logic cmd, input logic brk,
    input logic reg_f, input logic [7:0] pos);
    logic [16:0] r;
    r = 17'h00000;
    if (emc) begin
      r = {1'b1, FC_EMC, FA_NONE};
    end else if (chk) begin
      r = {1'b1, FC_CFG, FA_CFG_CHK};
    end else if (ovf) begin
      r = {1'b1, FC_CFG, FA_CFG_OVF};
    end else if (typ) begin
      r = {1'b1, FC_CFG, FA_CFG_TYPE};
    end else if (cmd) begin
      r = {1'b1, FC_CMD, FA_NONE};
    end else if (brk) begin
      r = {1'b1, FC_BREAK, pos};
    end else if (reg_f) begin
      r = {1'b1, FC_REG, pos};
    end
    return r;
  endfunction : pick_fault

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic apb_acc;
  logic apb_wr;
  logic hit_state;
  logic hit_fault;
  logic hit_ctrl;
  logic hit_istat;
  logic hit_imask;
  logic hit_any;

  // One wait state: pready rises in the first access cycle's edge
  assign apb_acc = psel && penable && !pready;
  // Writes land only at the edge that completes the transfer
  assign apb_wr = psel && penable && pready && pwrite && pstrb[0];

  always_comb begin
    hit_state = 1'b0;
    hit_fault = 1'b0;
    hit_ctrl = 1'b0;
    hit_istat = 1'b0;
    hit_imask = 1'b0;
    if (paddr == OFS_STATE) begin
      hit_state = 1'b1;
    end else if (paddr == OFS_FAULT) begin
      hit_fault = 1'b1;
    end else if (paddr == OFS_CTRL) begin
      hit_ctrl = 1'b1;
    end else if (paddr == OFS_IRQ_STAT) begin
      hit_istat = 1'b1;
    end else if (paddr == OFS_IRQ_MASK) begin
      hit_imask = 1'b1;
    end
  end

  assign hit_any = hit_state | hit_fault | hit_ctrl | hit_istat | hit_imask;

  // ---------------------------------------------------------------
  // Fault latch
  // ---------------------------------------------------------------
  logic [16:0] new_fault;
  logic clr_fault;
  logic clr_retrig;
  logic fault_act_q;
  logic [7:0] fault_code_q;
  logic [7:0] fault_arg_q;
  logic overrun_q;
  logic retrig_q;
  logic [7:0] state_byte;

  assign new_fault = pick_fault(ev_emc, ev_cfg_chk, ev_cfg_ovf, ev_cfg_type,
                                ev_cmd_fail, ev_break, ev_reg_fail,
                                fault_pos);
  assign clr_fault = apb_wr && hit_ctrl && pwdata[CTRL_CLR_FAULT];
  assign clr_retrig = apb_wr && hit_ctrl && pwdata[CTRL_CLR_RETRIG];

  // First fault is kept so the root cause is not overwritten by
  // the follow-on errors it usually triggers.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fault_act_q <= 1'b0;
      fault_code_q <= 8'h00;
      fault_arg_q <= 8'h00;
    end else if (new_fault[16] && (!fault_act_q || clr_fault)) begin
      fault_act_q <= 1'b1;
      fault_code_q <= new_fault[15:8];
      fault_arg_q <= new_fault[7:0];
    end else if (clr_fault) begin
      fault_act_q <= 1'b0;
    end
  end

  // Only a reset clears the overrun warning
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      overrun_q <= 1'b0;
    end else if (ev_overrun) begin
      overrun_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      retrig_q <= 1'b0;
    end else if (bus_retrig) begin
      retrig_q <= 1'b1;
    end else if (clr_retrig) begin
      retrig_q <= 1'b0;
    end
  end

  always_comb begin
    state_byte = STATE_RST;
    state_byte[ST_BUS_ERR] = fault_act_q;
    state_byte[ST_RETRIG] = retrig_q;
  end

  // ---------------------------------------------------------------
  // Message read answer
  // ---------------------------------------------------------------
  logic msg_match;

  assign msg_match = (msg_port == MSG_PORT) &&
                     (selector_group == MSG_GROUP) &&
                     (selector_offset == MSG_OFFSET) &&
                     (msg_len == MSG_LEN);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      msg_ack <= 1'b0;
      msg_err <= 1'b0;
      msg_data <= 8'h00;
    end else begin
      msg_ack <= message_read_request;
      msg_err <= message_read_request && !msg_match;
      if (message_read_request && msg_match) begin
        msg_data <= state_byte;
      end else begin
        msg_data <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // Run indicator
  // ---------------------------------------------------------------
  logic [31:0] idle_cnt_q;
  logic run_lost;

  assign run_lost = run_indicator && !bus_cycle &&
                    (idle_cnt_q >= RUN_TIMEOUT - 32'd1);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt_q <= 32'h0000_0000;
      run_indicator <= 1'b0;
    end else if (bus_cycle) begin
      idle_cnt_q <= 32'h0000_0000;
      run_indicator <= 1'b1;
    end else if (run_lost) begin
      run_indicator <= 1'b0;
    end else if (run_indicator) begin
      idle_cnt_q <= idle_cnt_q + 32'd1;
    end
  end

  // ---------------------------------------------------------------
  // Flash tick divider and fault indicator
  // ---------------------------------------------------------------
  logic [31:0] div_q;
  logic tick_q;
  logic show;
  logic [7:0] show_code;
  logic [7:0] show_arg;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else if (div_q >= TICK_DIV - 32'd1) begin
      div_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 32'd1;
      tick_q <= 1'b0;
    end
  end

  // An error outranks the overrun warning on the indicator
  assign show = fault_act_q || overrun_q;
  assign show_code = fault_act_q ? fault_code_q : FC_OVERRUN;
  assign show_arg = fault_act_q ? fault_arg_q : FA_NONE;

  tbd_flasher u_flasher (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(tick_q),
    .show(show),
    .code(show_code),
    .arg(show_arg),
    .led_q(fault_indicator)
  );

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  always_comb begin
    irq_set = '0;
    irq_set[IRQ_FAULT] = new_fault[16];
    irq_set[IRQ_WARN] = ev_overrun;
    irq_set[IRQ_RETRIG] = bus_retrig;
    irq_set[IRQ_RUNLOST] = run_lost;
  end

  assign irq_clr = (apb_wr && hit_istat) ? pwdata[IRQ_W-1:0] : '0;

  // A new event in the clearing cycle stays set
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_mask_q <= IRQ_MASK_RST;
    end else if (apb_wr && hit_imask) begin
      irq_mask_q <= pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irq_stat_q & ~irq_clr | irq_set) & irq_mask_q);
    end
  end

  // ---------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (apb_acc) begin
      pready <= 1'b1;
      pslverr <= !hit_any;
      prdata <= 32'h0000_0000;
      if (!pwrite) begin
        if (hit_state) begin
          prdata <= {24'h000000, state_byte};
        end else if (hit_fault) begin
          prdata <= {14'h0000, overrun_q, fault_act_q,
                     fault_code_q, fault_arg_q};
        end else if (hit_istat) begin
          prdata <= {28'h0000000, irq_stat_q};
        end else if (hit_imask) begin
          prdata <= {28'h0000000, irq_mask_q};
        end
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule : tbd_diag

// File: test/tbd_partner.sv
`timescale 1ns/1ps
module tbd_partner
  import tbd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic run_en,
  input wire logic ask,
  input wire logic bad,
  output logic bus_cycle,
  output logic message_read_request,
  output logic [15:0] msg_port,
  output logic [31:0] selector_group,
  output logic [31:0] selector_offset,
  output logic [15:0] msg_len
);
  // ---------------------------------------------------------------
  // Terminal bus engine and requester
  // ---------------------------------------------------------------
  logic [2:0] cnt_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 3'h0;
    end else if (run_en) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
  // Update cycles stop the moment the engine is halted
  assign bus_cycle = run_en && cnt_q == 3'h7;

  // Fields are inverted when idle so stale selectors never look valid
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn || !ask) begin
      message_read_request <= 1'b0;
      msg_port <= ~MSG_PORT;
      selector_group <= ~MSG_GROUP;
      selector_offset <= ~MSG_OFFSET;
      msg_len <= ~MSG_LEN;
    end else begin
      message_read_request <= 1'b1;
      msg_port <= MSG_PORT;
      selector_group <= bad ? MSG_GROUP ^ 32'h1 : MSG_GROUP;
      selector_offset <= MSG_OFFSET;
      msg_len <= MSG_LEN;
    end
  end
endmodule : tbd_partner

// File: test/tbd_diag_props.sv
`timescale 1ns/1ps
module tbd_diag_chk
  import tbd_pkg::*;
#(
  parameter int unsigned RUN_TIMEOUT = 50,
  parameter int unsigned TICK_DIV = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic bus_cycle,
  input wire logic bus_retrig,
  input wire logic ev_emc,
  input wire logic ev_cfg_chk,
  input wire logic ev_cfg_ovf,
  input wire logic ev_cfg_type,
  input wire logic ev_cmd_fail,
  input wire logic ev_break,
  input wire logic ev_reg_fail,
  input wire logic ev_overrun,
  input wire logic message_read_request,
  input wire logic [15:0] msg_port,
  input wire logic [31:0] selector_group,
  input wire logic [31:0] selector_offset,
  input wire logic [15:0] msg_len,
  input wire logic msg_ack,
  input wire logic msg_err,
  input wire logic [7:0] msg_data,
  input wire logic run_indicator,
  input wire logic fault_indicator
);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Longest dark spell of a latched warning: pulse off, gap, rest
  localparam int DARK_MAX = 3300 * TICK_DIV;
  logic ok, flt, seen_q, warn_q;
  logic [31:0] idle_q, dark_q;
  assign ok = msg_port == MSG_PORT && selector_group == MSG_GROUP &&
              selector_offset == MSG_OFFSET && msg_len == MSG_LEN;
  assign flt = ev_emc | ev_cfg_chk | ev_cfg_ovf | ev_cfg_type |
               ev_cmd_fail | ev_break | ev_reg_fail;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      seen_q <= 1'b0;
      warn_q <= 1'b0;
    end else begin
      seen_q <= seen_q | flt | ev_overrun;
      warn_q <= warn_q | ev_overrun;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn || bus_cycle) begin
      idle_q <= '0;
    end else if (idle_q != '1) begin
      idle_q <= idle_q + 32'h1;
    end
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn || !warn_q || fault_indicator) begin
      dark_q <= '0;
    end else begin
      dark_q <= dark_q + 32'h1;
    end
  end

  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  msg_ack_a: assert property (message_read_request |=> msg_ack)
    else $error("message request not answered");
  msg_ok_a: assert property (
    message_read_request && ok |=> !msg_err)
    else $error("valid message request refused");
  msg_bad_a: assert property (
    message_read_request && !ok |=> msg_err && msg_data == 8'h00)
    else $error("bad selectors not refused");
  state_err_a: assert property (
    (flt ##1 (message_read_request && ok)) |=> msg_data[0])
    else $error("error bit missing after fault");
  state_rtg_a: assert property (
    (bus_retrig ##1 (message_read_request && ok)) |=> msg_data[2])
    else $error("retrigger bit missing");
  run_lit_a: assert property (bus_cycle |=> run_indicator)
    else $error("run indicator dark after update cycle");
  run_dark_a: assert property (
    idle_q > RUN_TIMEOUT + 2 |-> !run_indicator)
    else $error("run indicator lit without update cycles");
  fault_dark_a: assert property (!seen_q |-> !fault_indicator)
    else $error("fault indicator lit without fault");
  warn_lit_a: assert property (dark_q < DARK_MAX)
    else $error("latched warning stopped flashing");
endmodule : tbd_diag_chk

bind tbd_diag tbd_diag_chk #(.RUN_TIMEOUT(RUN_TIMEOUT), .TICK_DIV(TICK_DIV))
  chk_i (.ref_clk, .resetn, .bus_cycle, .bus_retrig, .ev_emc, .ev_cfg_chk,
  .ev_cfg_ovf, .ev_cfg_type, .ev_cmd_fail, .ev_break, .ev_reg_fail,
  .ev_overrun, .message_read_request, .msg_port, .selector_group,
  .selector_offset, .msg_len, .msg_ack, .msg_err, .msg_data,
  .run_indicator, .fault_indicator);

// File: test/tbd_diag_tb_top.sv
`timescale 1ns/1ps
module tbd_diag_tb_top;
  import tbd_pkg::*;
  // ---------------------------------------------------------------
  // Bench
  // ---------------------------------------------------------------
  // Short counts keep the flash sequences inside the run budget
  localparam int unsigned RT = 50;
  localparam int unsigned TD = 4;
  typedef struct {int i; logic [7:0] p, c, a; bit m;} tbd_row_s;
  logic ref_clk = 1'b0, resetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, selector_group, selector_offset, rd;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, msg_ack, msg_err, run_indicator, fault_indicator;
  logic irq, bus_cycle, message_read_request, er;
  logic [7:0] msg_data, fault_pos = 8'h00;
  logic [15:0] msg_port, msg_len;
  logic [8:0] ev = 9'h000;
  logic run_en = 1'b0, ask = 1'b0, bad = 1'b0;
  int error_cnt = 0, checked = 0;
  tbd_row_s rows [8] = '{
    '{1, 8'h00, FC_CFG, FA_CFG_CHK, 1'b0},
    '{0, 8'h00, FC_EMC, FA_NONE, 1'b1},
    '{2, 8'h00, FC_CFG, FA_CFG_OVF, 1'b0},
    '{3, 8'h00, FC_CFG, FA_CFG_TYPE, 1'b0},
    '{4, 8'h00, FC_CMD, FA_NONE, 1'b1}, '{5, 8'h00, FC_BREAK, 8'h00, 1'b0},
    '{5, 8'h01, FC_BREAK, 8'h01, 1'b1}, '{6, 8'h02, FC_REG, 8'h02, 1'b1}};

  always #2.5 ref_clk = ~ref_clk;

  tbd_diag #(.RUN_TIMEOUT(RT), .TICK_DIV(TD)) uut (.ref_clk, .resetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .bus_cycle, .bus_retrig(ev[8]), .ev_emc(ev[0]), .ev_cfg_chk(ev[1]),
    .ev_cfg_ovf(ev[2]), .ev_cfg_type(ev[3]), .ev_cmd_fail(ev[4]),
    .ev_break(ev[5]), .ev_reg_fail(ev[6]), .ev_overrun(ev[7]), .fault_pos,
    .message_read_request, .msg_port, .selector_group, .selector_offset,
    .msg_len, .msg_ack, .msg_err, .msg_data, .run_indicator,
    .fault_indicator, .irq);
  tbd_partner u_far (.ref_clk, .resetn, .run_en, .ask, .bad, .bus_cycle,
    .message_read_request, .msg_port, .selector_group, .selector_offset,
    .msg_len);

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Event and message request leave together; i of 9 raises no event
  task automatic fire(input int i, input logic b, input logic [7:0] p);
    @(posedge ref_clk);
    ev <= 9'h001 << i;
    ask <= 1'b1;
    bad <= b;
    fault_pos <= p;
    @(posedge ref_clk);
    ev <= 9'h000;
    ask <= 1'b0;
    @(posedge ref_clk);
    while (msg_ack !== 1'b1) @(posedge ref_clk);
    rd = {23'h0, msg_err, msg_data};
  endtask : fire

  task automatic flash(input int c, input int a);
    int w, t, n, n1;
    bit lst;
    w = ((c + a) * 2 * PULSE_TICKS + GAP_TICKS + REST_TICKS / 2) * TD;
    if (c == 0) w = GAP_TICKS * TD;
    n = 0;
    n1 = 0;
    lst = 1'b0;
    for (t = 0; t < w; t++) begin
      @(posedge ref_clk);
      if (fault_indicator === 1'b1 && !lst) n++;
      lst = fault_indicator === 1'b1;
      if (t == (c * 2 * PULSE_TICKS + GAP_TICKS / 2) * TD) n1 = n;
    end
    if (c == 0) begin
      chk(32'(n >= 9), 32'h1);
    end else begin
      chk(32'(n1), 32'(c));
      chk(32'(n), 32'(c + a));
    end
  endtask : flash

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  initial begin
    repeat (90000) @(posedge ref_clk);
    error_cnt++;
    wrap_up();
  end

  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk(rd, {28'h0, IRQ_MASK_RST});
    apb(1'b0, OFS_STATE, 32'h0);
    chk(rd, {24'h0, STATE_RST});
    chk({run_indicator, fault_indicator, irq}, 32'h0);
    foreach (rows[k]) begin
      fire(rows[k].i, 1'b0, rows[k].p);
      chk(rd, 32'h001);
      apb(1'b0, OFS_FAULT, 32'h0);
      chk(rd, {15'h0, 1'b1, rows[k].c,
               rows[k].a});
      if (rows[k].m) flash(rows[k].c, rows[k].a);
      apb(1'b1, OFS_CTRL, 32'h1);
      apb(1'b1, OFS_IRQ_STAT, 32'hF);
      chk(fault_indicator, 32'h0);
    end
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    fire(4, 1'b0, 8'h00);
    repeat (2) @(posedge ref_clk);
    chk(irq, 32'h1);
    fire(6, 1'b0, 8'h05);
    apb(1'b0, OFS_FAULT, 32'h0);
    chk(rd, {15'h0, 1'b1, FC_CMD, FA_NONE});
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(irq, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b1, OFS_IRQ_STAT, 32'hF);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk(irq, 32'h0);
    pstrb <= 4'h0;
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, OFS_IRQ_MASK, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    fire(9, 1'b1, 8'h00);
    chk(rd, 32'h100);
    fire(8, 1'b0, 8'h00);
    chk(rd, 32'h004);
    apb(1'b1, OFS_CTRL, 32'h2);
    fire(9, 1'b0, 8'h00);
    chk(rd, 32'h000);
    run_en <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk(run_indicator, 32'h1);
    run_en <= 1'b0;
    repeat (RT + 20) @(posedge ref_clk);
    chk(run_indicator, 32'h0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd & 32'h8, 32'h8);
    fire(7, 1'b0, 8'h00);
    chk(rd, 32'h000);
    flash(FC_OVERRUN, 0);
    apb(1'b1, OFS_CTRL, 32'h1);
    apb(1'b0, OFS_FAULT, 32'h0);
    chk(rd & 32'h30000, 32'h20000);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    apb(1'b0, OFS_FAULT, 32'h0);
    chk(rd & 32'h30000, 32'h0);
    chk(fault_indicator, 32'h0);
    wrap_up();
  end
endmodule : tbd_diag_tb_top
